//--- design/lpc_regs.sv
// LED control and PHY control register bank with AHB-Lite slave and interrupt.
// Assumes one clock, straps settled at reset release, PHY status on the same clock.
//
// How it works
// - Blink-rate field picks phase 50, 100, 200 or 500 ms.
// - Polarity bit set makes the LED active high, cleared active low.
// - Polarity starts from the LED pin strap; later writes override it.
// - Override-select drives the force-value bit straight onto the LED pin.
// - Auto-crossover enable bit turns automatic pair crossover on or off.
// - Forced crossover swaps receive and transmit pairs.
// - Receive-pause status resolved from both adverts, only in full duplex.
// - Transmit-pause status resolved from both adverts, only in full duplex.
// - Link status bit reads one only with 100 Mb/s full-duplex link.
// - Stretch-bypass shows raw activity instead of stretched activity.
// - Meaning bit one: LED shows link; zero: link plus activity blink.
`timescale 1ns/1ns
`include "lpc_defines.svh"
module lpc_regs
   import lpc_pkg::*;
#(
   parameter logic [25:0] BLINK_CYC_0 = 26'(`LPC_MS_CYC(`LPC_BLINK_MS_0)),
   parameter logic [25:0] BLINK_CYC_1 = 26'(`LPC_MS_CYC(`LPC_BLINK_MS_1)),
   parameter logic [25:0] BLINK_CYC_2 = 26'(`LPC_MS_CYC(`LPC_BLINK_MS_2)),
   parameter logic [25:0] BLINK_CYC_3 = 26'(`LPC_MS_CYC(`LPC_BLINK_MS_3))
)(
   input  wire logic        clk,
   input  wire logic        rst_n,
   input  wire logic        hsel,
   input  wire logic [31:0] haddr,
   input  wire logic [1:0]  htrans,
   input  wire logic        hwrite,
   input  wire logic [2:0]  hsize,
   input  wire logic [31:0] hwdata,
   input  wire logic        hready,
   output logic             hreadyout,
   output logic             hresp,
   output logic [31:0]      hrdata,
   input  wire lpc_phy_s    phyStat,
   input  wire lpc_strap_s  strapIn,
   output logic             statusLedPinOut,
   output logic             statusLedPinOe,
   output logic             autoXoverEn,
   output logic             crossPairs,
   output logic             pauseRxEn,
   output logic             pauseTxEn,
   output logic             irq
);

   lpc_strap_s strapMeta;
   lpc_strap_s strapSync;
   logic [1:0] strapCnt;
   logic [1:0] next_strapCnt;
   logic       strapDone;
   logic       next_strapDone;
   logic [4:0] strapAddr;
   logic [4:0] next_strapAddr;
   lpc_bus_e   busState;
   lpc_bus_e   next_busState;
   logic       next_hreadyout;
   logic [31:0] next_hrdata;
   lpc_sel_t   wrSel;
   lpc_sel_t   next_wrSel;
   lpc_sel_t   rdSel;
   lpc_sel_t   next_rdSel;
   logic [15:0] ledReg;
   logic [15:0] next_ledReg;
   logic [15:0] phyRw;
   logic [15:0] next_phyRw;
   logic [1:0] irqStat;
   logic [1:0] next_irqStat;
   logic [1:0] irqMask;
   logic [1:0] next_irqMask;
   logic [1:0] evt;
   logic       pauseRx;
   logic       pauseTx;
   logic       linkFdx;
   logic       next_pauseRx;
   logic       next_pauseTx;
   logic       next_linkFdx;
   logic       next_pinOut;
   logic       next_irq;
   logic       ledBase;
   logic       blinkPhase;
   logic       actShown;
   logic [25:0] phaseLen;
   logic [15:0] wd;
   logic       take;

   function automatic lpc_sel_t lpc_decode(input logic [31:0] a);
      lpc_sel_t s;
      s = 4'h0;
      if (a[31:10] == 22'h0 && a[1:0] == 2'h0) begin
         s[0] = (a[9:2] == `LPC_IDX_LED);
         s[1] = (a[9:2] == `LPC_IDX_PHY);
         s[2] = (a[9:2] == `LPC_IDX_IRQ_STAT);
         s[3] = (a[9:2] == `LPC_IDX_IRQ_MASK);
      end
      return s;
   endfunction

   // Straps come from pins, so they pass two flip-flops before use.
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         strapMeta <= '0;
         strapSync <= '0;
      end else begin
         strapMeta <= strapIn;
         strapSync <= strapMeta;
      end
   end

   always_comb begin
      wd             = hwdata[15:0];
      take           = hsel && htrans[1] && hready && (busState == LPC_BUS_IDLE);
      next_strapCnt  = strapCnt;
      next_strapDone = strapDone;
      next_strapAddr = strapAddr;
      next_busState  = busState;
      next_hreadyout = hreadyout;
      next_hrdata    = hrdata;
      next_wrSel     = 4'h0;
      next_rdSel     = rdSel;
      next_ledReg    = ledReg;
      next_phyRw     = phyRw;
      next_irqMask   = irqMask;
      next_irqStat   = irqStat;
      // Straps are caught once the synchroniser has filled after reset release.
      if (!strapDone) begin
         next_strapCnt = strapCnt + 2'h1;
         if (strapCnt == `LPC_STRAP_CYC) begin
            next_strapDone                = 1'b1;
            next_strapAddr                = strapSync.addr;
            next_ledReg[`LPC_F_LED_POL]   = strapSync.ledPol;
            next_phyRw[`LPC_F_AUTOX]      = strapSync.autoX;
            next_phyRw[`LPC_F_MEANING]    = strapSync.meaning;
         end
      end
      // Write data phase; a write landing with the strap capture wins over it.
      if (wrSel[0]) begin
         next_ledReg = wd & `LPC_WMASK_LED;
      end
      if (wrSel[1]) begin
         next_phyRw = wd & `LPC_WMASK_PHY;
      end
      if (wrSel[2]) begin
         next_irqStat = irqStat & ~wd[1:0];
      end
      if (wrSel[3]) begin
         next_irqMask = wd[1:0];
      end
      case (busState)
         LPC_BUS_IDLE: begin
            if (take) begin
               if (hwrite) begin
                  next_wrSel = lpc_decode(haddr);
               end else begin
                  // A wait state lets a read see a write that ended just before it.
                  next_rdSel     = lpc_decode(haddr);
                  next_hreadyout = 1'b0;
                  next_busState  = LPC_BUS_RDWAIT;
               end
            end
         end
         LPC_BUS_RDWAIT: begin
            next_hrdata = 32'h0;
            if (rdSel[0]) begin
               next_hrdata[15:0] = ledReg;
            end
            if (rdSel[1]) begin
               next_hrdata[15:0] = phyRw | {2'h0, pauseRx, pauseTx, linkFdx, 6'h0, strapAddr};
            end
            if (rdSel[2]) begin
               next_hrdata[1:0] = irqStat;
            end
            if (rdSel[3]) begin
               next_hrdata[1:0] = irqMask;
            end
            next_hreadyout = 1'b1;
            next_busState  = LPC_BUS_IDLE;
         end
         default: begin
            next_hreadyout = 1'b1;
            next_busState  = LPC_BUS_IDLE;
         end
      endcase
   end

   // Set wins over a write-one clear in the same cycle.
   genvar g;
   generate
      for (g = 0; g < 2; g++) begin : gSticky
         always_ff @(posedge clk or negedge rst_n) begin
            if (!rst_n) begin
               irqStat[g] <= 1'b0;
            end else begin
               irqStat[g] <= next_irqStat[g] | evt[g];
            end
         end
      end
   endgenerate

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         strapCnt  <= 2'h0;
         strapDone <= 1'b0;
         strapAddr <= 5'h0;
         busState  <= LPC_BUS_IDLE;
         hreadyout <= 1'b1;
         hresp     <= 1'b0;
         hrdata    <= 32'h0;
         wrSel     <= 4'h0;
         rdSel     <= 4'h0;
         ledReg    <= `LPC_RST_LED;
         phyRw     <= `LPC_RST_PHY;
         irqMask   <= `LPC_RST_IRQ;
      end else begin
         strapCnt  <= next_strapCnt;
         strapDone <= next_strapDone;
         strapAddr <= next_strapAddr;
         busState  <= next_busState;
         hreadyout <= next_hreadyout;
         hresp     <= 1'b0;
         hrdata    <= next_hrdata;
         wrSel     <= next_wrSel;
         rdSel     <= next_rdSel;
         ledReg    <= next_ledReg;
         phyRw     <= next_phyRw;
         irqMask   <= next_irqMask;
      end
   end

   always_comb begin
      case (ledReg[`LPC_F_BLINK_HI:`LPC_F_BLINK_LO])
         2'h0:    phaseLen = BLINK_CYC_0;
         2'h1:    phaseLen = BLINK_CYC_1;
         2'h2:    phaseLen = BLINK_CYC_2;
         default: phaseLen = BLINK_CYC_3;
      endcase
   end

   lpc_led_timer uTimer (
      .clk        (clk),
      .rst_n      (rst_n),
      .phaseLen   (phaseLen),
      .activity   (phyStat.activity),
      .bypass     (phyRw[`LPC_F_BYPASS]),
      .blinkPhase (blinkPhase),
      .actShown   (actShown)
   );

   always_comb begin
      // Pause resolution: symmetric when both pause, else asymmetric direction.
      next_pauseTx = phyStat.fdxHcd && ((phyStat.localAdv[0] && phyStat.partnerAdv[0]) ||
                     (!phyStat.localAdv[0] && (&phyStat.localAdv[1]) &&
                      (&phyStat.partnerAdv)));
      next_pauseRx = phyStat.fdxHcd && ((phyStat.localAdv[0] && phyStat.partnerAdv[0]) ||
                     ((&phyStat.localAdv) && !phyStat.partnerAdv[0] &&
                      phyStat.partnerAdv[1]));
      next_linkFdx = phyStat.link100Fdx;
      evt[`LPC_EV_LINK]  = (next_linkFdx != linkFdx);
      evt[`LPC_EV_PAUSE] = (next_pauseRx != pauseRx) || (next_pauseTx != pauseTx);
      if (phyRw[`LPC_F_MEANING]) begin
         ledBase = phyStat.linkUp;
      end else begin
         ledBase = phyStat.linkUp && (!actShown || blinkPhase);
      end
      if (ledReg[`LPC_F_LED_FORCE]) begin
         next_pinOut = ledReg[`LPC_F_LED_VAL];
      end else begin
         next_pinOut = ledReg[`LPC_F_LED_POL] ? ledBase : ~ledBase;
      end
      next_irq = |(irqStat & irqMask);
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         pauseRx         <= 1'b0;
         pauseTx         <= 1'b0;
         linkFdx         <= 1'b0;
         statusLedPinOut <= 1'b0;
         statusLedPinOe  <= 1'b0;
         autoXoverEn     <= 1'b0;
         crossPairs      <= 1'b0;
         pauseRxEn       <= 1'b0;
         pauseTxEn       <= 1'b0;
         irq             <= 1'b0;
      end else begin
         pauseRx         <= next_pauseRx;
         pauseTx         <= next_pauseTx;
         linkFdx         <= next_linkFdx;
         statusLedPinOut <= next_pinOut;
         statusLedPinOe  <= strapDone;  // The pin stays released while its strap is read.
         autoXoverEn     <= phyRw[`LPC_F_AUTOX];
         crossPairs      <= phyRw[`LPC_F_XOVER];
         pauseRxEn       <= pauseRx;
         pauseTxEn       <= pauseTx;
         irq             <= next_irq;
      end
   end

   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_n);

   AST_POLARITY: assert property (strapDone && !ledReg[`LPC_F_LED_FORCE]
      |=> statusLedPinOut == ($past(ledReg[`LPC_F_LED_POL]) ? $past(ledBase) : !$past(ledBase)))
      else $error("LED pin does not follow the polarity setting.");
   AST_STRAP_POL: assert property ($rose(strapDone) && !$past(wrSel[0])
      |-> ledReg[`LPC_F_LED_POL] == $past(strapSync.ledPol))
      else $error("Strapped LED polarity was not loaded.");
   AST_FORCE: assert property (ledReg[`LPC_F_LED_FORCE]
      |=> statusLedPinOut == $past(ledReg[`LPC_F_LED_VAL]))
      else $error("Forced LED value not driven onto the pin.");
   AST_AUTOX: assert property ($changed(phyRw[`LPC_F_AUTOX])
      |=> autoXoverEn == $past(phyRw[`LPC_F_AUTOX]))
      else $error("Auto crossover enable does not follow its bit.");
   AST_XOVER: assert property (phyRw[`LPC_F_XOVER] [*2] |-> crossPairs)
      else $error("Forced crossover not applied.");
   AST_PAUSE_HDX: assert property (!phyStat.fdxHcd ##1 !phyStat.fdxHcd
      |-> !pauseRx && !pauseTx ##1 !pauseRxEn && !pauseTxEn)
      else $error("Pause resolved without full duplex.");
   AST_LINK: assert property (phyStat.link100Fdx |=> linkFdx)
      else $error("Link status bit missed the 100 Mb/s full-duplex link.");
   AST_MEANING: assert property (strapDone && phyRw[`LPC_F_MEANING]
      && !ledReg[`LPC_F_LED_FORCE] && ledReg[`LPC_F_LED_POL]
      |=> statusLedPinOut == $past(phyStat.linkUp))
      else $error("LED does not show plain link state.");
   AST_ADDR_RO: assert property (strapDone && $past(strapDone) |-> $stable(strapAddr))
      else $error("Strapped address changed after capture.");
   AST_STICKY: assert property (evt[`LPC_EV_LINK] |=> irqStat[`LPC_EV_LINK] ##1 irq == $past(
      |(irqStat & irqMask)))
      else $error("Event lost or interrupt level wrong.");
   AST_READ_WAIT: assert property (busState == LPC_BUS_RDWAIT |-> !hreadyout ##1 hreadyout)
      else $error("Read did not complete after one wait state.");

   COV_READ: cover property (take && !hwrite ##2 hreadyout);
   COV_WRITE_LED: cover property (wrSel[0] ##1 ledReg[`LPC_F_LED_FORCE]);
   COV_IRQ: cover property ($rose(irq));
   COV_BLINK: cover property (actShown && !phyRw[`LPC_F_MEANING] && $changed(blinkPhase));

endmodule

//--- design/lpc_defines.svh
// Register indices, field positions, reset values and timing figures of the LED/PHY control bank.
// Assumes a 100 MHz system clock; byte address of a register is four times its index.
`ifndef LPC_DEFINES_SVH
`define LPC_DEFINES_SVH

`define LPC_IDX_LED       8'h18
`define LPC_IDX_PHY       8'h19
`define LPC_IDX_IRQ_STAT  8'h1C
`define LPC_IDX_IRQ_MASK  8'h1D

`define LPC_F_BLINK_HI    10
`define LPC_F_BLINK_LO    9
`define LPC_F_LED_POL     7
`define LPC_F_LED_FORCE   4
`define LPC_F_LED_VAL     1
`define LPC_F_AUTOX       15
`define LPC_F_XOVER       14
`define LPC_F_BYPASS      7
`define LPC_F_MEANING     5

`define LPC_WMASK_LED     16'h07FF
`define LPC_WMASK_PHY     16'hC0E0
`define LPC_RST_LED       16'h0000
`define LPC_RST_PHY       16'h0020
`define LPC_RST_IRQ       2'h0

`define LPC_EV_LINK       0
`define LPC_EV_PAUSE      1

`define LPC_CLK_MHZ       100
`define LPC_BLINK_MS_0    50
`define LPC_BLINK_MS_1    100
`define LPC_BLINK_MS_2    200
`define LPC_BLINK_MS_3    500
`define LPC_MS_CYC(ms)    ((ms) * 1000 * `LPC_CLK_MHZ)
`define LPC_STRAP_CYC     2'h3

`endif

//--- design/lpc_pkg.sv
// Types shared by the LED/PHY control bank.
// Assumes lpc_defines.svh supplies all numeric constants.
package lpc_pkg;

   typedef struct packed {
      logic [1:0] localAdv;    // Local advertisement {asym, pause}.
      logic [1:0] partnerAdv;  // Partner ability {asym, pause}.
      logic       fdxHcd;      // Common mode resolved to full duplex.
      logic       link100Fdx;  // 100 Mb/s full-duplex link up.
      logic       linkUp;
      logic       activity;
   } lpc_phy_s;

   typedef struct packed {
      logic       autoX;
      logic       meaning;
      logic [4:0] addr;
      logic       ledPol;
   } lpc_strap_s;

   typedef enum logic [0:0] {
      LPC_BUS_IDLE,
      LPC_BUS_RDWAIT
   } lpc_bus_e;

   typedef logic [3:0] lpc_sel_t;

endpackage

//--- design/lpc_led_timer.sv
// Blink phase generator and activity stretcher for the status LED.
// Assumes activity comes from logic on the same clock.
`timescale 1ns/1ns
`include "lpc_defines.svh"
module lpc_led_timer
   import lpc_pkg::*;
(
   input  wire logic        clk,
   input  wire logic        rst_n,
   input  wire logic [25:0] phaseLen,
   input  wire logic        activity,
   input  wire logic        bypass,
   output logic             blinkPhase,
   output logic             actShown
);

   logic [25:0] cnt;
   logic [25:0] next_cnt;
   logic        next_blinkPhase;
   logic        stretch;
   logic        next_stretch;
   logic        wrap;

   always_comb begin
      // Comparing with >= lets a switch to a faster rate take effect at once.
      wrap            = (cnt >= phaseLen - 26'h1);
      next_cnt        = wrap ? 26'h0 : cnt + 26'h1;
      next_blinkPhase = wrap ? ~blinkPhase : blinkPhase;
      // Activity is held to the end of the phase so that one short frame stays visible.
      next_stretch    = activity | (stretch & ~wrap);
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         cnt        <= 26'h0;
         blinkPhase <= 1'b0;
         stretch    <= 1'b0;
      end else begin
         cnt        <= next_cnt;
         blinkPhase <= next_blinkPhase;
         stretch    <= next_stretch;
      end
   end

   assign actShown = bypass ? activity : stretch;

   AST_PHASE_AT_END: assert property (@(posedge clk) disable iff (!rst_n)
      $changed(blinkPhase) |-> $past(cnt) >= $past(phaseLen) - 26'h1)
      else $error("Blink phase changed before the phase length elapsed.");

endmodule

//--- dv/tb.sv
// Self-checking bench for the LED and PHY control register bank.
// Assumes lpc_pkg is compiled first and lpc_defines.svh is on the include path.
`timescale 1ns/1ns
`include "lpc_defines.svh"
module tb
   import lpc_pkg::*;
;
   localparam logic [31:0] A_LED  = 32'(`LPC_IDX_LED) << 2;
   localparam logic [31:0] A_PHY  = 32'(`LPC_IDX_PHY) << 2;
   localparam logic [31:0] A_STAT = 32'(`LPC_IDX_IRQ_STAT) << 2;
   localparam logic [31:0] A_MASK = 32'(`LPC_IDX_IRQ_MASK) << 2;
   // Short blink phases keep the run brief; expectations use the same table.
   localparam logic [25:0] PH [4] = '{26'h08, 26'h10, 26'h20, 26'h50};

   logic        clk;
   logic        rst_n;
   logic        hsel;
   logic [31:0] haddr;
   logic [1:0]  htrans;
   logic        hwrite;
   logic [2:0]  hsize;
   logic [31:0] hwdata;
   logic        hreadyout;
   logic        hresp;
   logic [31:0] hrdata;
   lpc_phy_s    phyStat;
   lpc_strap_s  strapIn;
   logic        statusLedPinOut;
   logic        statusLedPinOe;
   logic        autoXoverEn;
   logic        crossPairs;
   logic        pauseRxEn;
   logic        pauseTxEn;
   logic        irq;
   int          fails;
   int          compares;
   int          gap;
   logic [31:0] rd;
   logic [4:0]  v;
   logic        expTx;
   logic        expRx;

   lpc_regs #(
      .BLINK_CYC_0 (PH[0]),
      .BLINK_CYC_1 (PH[1]),
      .BLINK_CYC_2 (PH[2]),
      .BLINK_CYC_3 (PH[3])
   ) i_lpc_regs (
      .clk             (clk),
      .rst_n           (rst_n),
      .hsel            (hsel),
      .haddr           (haddr),
      .htrans          (htrans),
      .hwrite          (hwrite),
      .hsize           (hsize),
      .hwdata          (hwdata),
      .hready          (hreadyout),
      .hreadyout       (hreadyout),
      .hresp           (hresp),
      .hrdata          (hrdata),
      .phyStat         (phyStat),
      .strapIn         (strapIn),
      .statusLedPinOut (statusLedPinOut),
      .statusLedPinOe  (statusLedPinOe),
      .autoXoverEn     (autoXoverEn),
      .crossPairs      (crossPairs),
      .pauseRxEn       (pauseRxEn),
      .pauseTxEn       (pauseTxEn),
      .irq             (irq)
   );

   always #5 clk = ~clk;

   task automatic stop_test();
      $display("counts: %0d compares, %0d fails", compares, fails);
      if (fails == 0 && compares > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask

   task automatic chk_reg(input logic [31:0] got, input logic [31:0] exp);
      compares++;
      if (got !== exp) begin
         fails++;
         $display("unexpected value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic chk_bit(input logic got, input logic exp);
      compares++;
      if (got !== exp) begin
         fails++;
         $display("unexpected bit at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   // Every wait is bounded so a stuck slave ends the run instead of hanging it.
   task automatic wait_ready();
      for (int i = 0; i < 40; i++) begin
         @(posedge clk);
         if (hreadyout === 1'b1) begin
            return;
         end
      end
      fails++;
      $display("unexpected timeout at %0t: got %h expected %h", $time, 1'b0, 1'b1);
      stop_test();
   endtask

   task automatic ahb_xfer(input logic [31:0] a, input logic w, input logic [31:0] d);
      hsel   <= 1'b1;
      htrans <= 2'h2;
      haddr  <= a;
      hwrite <= w;
      wait_ready();
      htrans <= 2'h0;
      hwdata <= w ? d : 32'h0;
      wait_ready();
      rd = hrdata;
      chk_bit(hresp, 1'b0);
   endtask

   task automatic ahb_write(input logic [31:0] a, input logic [31:0] d);
      ahb_xfer(a, 1'b1, d);
      repeat (2) @(posedge clk);
   endtask

   task automatic ahb_read(input logic [31:0] a);
      ahb_xfer(a, 1'b0, 32'h0);
   endtask

   // Counts cycles until the LED pin changes level.
   task automatic wait_toggle(output int n);
      logic last;
      last = statusLedPinOut;
      for (n = 1; n < 400; n++) begin
         @(posedge clk);
         if (statusLedPinOut !== last) begin
            return;
         end
      end
      fails++;
      $display("unexpected timeout at %0t: got %h expected %h", $time, last, ~last);
      stop_test();
   endtask

   initial begin
      clk = 1'b0;
      rst_n = 1'b0;
      hsel = 1'b0;
      haddr = 32'h0;
      htrans = 2'h0;
      hwrite = 1'b0;
      hsize = 3'h2;
      hwdata = 32'h0;
      phyStat = '0;
      strapIn = '{autoX: 1'b1, meaning: 1'b0, addr: 5'h15, ledPol: 1'b1};
      fails = 0;
      compares = 0;
      repeat (3) @(posedge clk);
      rst_n <= 1'b1;
      repeat (8) @(posedge clk);
      chk_bit(statusLedPinOe, 1'b1);
      ahb_read(A_LED);
      chk_reg(rd, 32'h0000_0080);
      ahb_read(A_PHY);
      chk_reg(rd, 32'h0000_8015);
      chk_bit(autoXoverEn, 1'b1);
      $display("test straps done");

      ahb_write(A_LED, 32'hFFFF_FFFF);
      chk_bit(statusLedPinOut, 1'b1);
      ahb_read(A_LED);
      chk_reg(rd, 32'h0000_07FF);
      ahb_write(A_LED, 32'h0000_0010);
      chk_bit(statusLedPinOut, 1'b0);
      ahb_write(A_PHY, 32'hFFFF_FFFF);
      chk_bit(crossPairs, 1'b1);
      ahb_read(A_PHY);
      chk_reg(rd, 32'h0000_C0F5);
      ahb_write(A_PHY, 32'h0000_0000);
      chk_bit(autoXoverEn, 1'b0);
      chk_bit(crossPairs, 1'b0);
      ahb_write(32'h0000_0068, 32'h0000_FFFF);
      ahb_read(32'h0000_0068);
      chk_reg(rd, 32'h0);
      $display("test access done");

      for (int i = 0; i < 32; i++) begin
         v = 5'(i);
         phyStat.localAdv <= v[1:0];
         phyStat.partnerAdv <= v[3:2];
         phyStat.fdxHcd <= v[4];
         repeat (3) @(posedge clk);
         expTx = v[4] & ((v[0] & v[2]) | (!v[0] & v[1] & v[2] & v[3]));
         expRx = v[4] & ((v[0] & v[2]) | (v[0] & v[1] & !v[2] & v[3]));
         chk_bit(pauseTxEn, expTx);
         chk_bit(pauseRxEn, expRx);
         ahb_read(A_PHY);
         chk_bit(rd[12], expTx);
         chk_bit(rd[13], expRx);
      end
      phyStat <= '0;
      $display("test pause done");

      ahb_write(A_STAT, 32'h0000_0003);
      ahb_read(A_STAT);
      chk_reg(rd, 32'h0);
      ahb_write(A_MASK, 32'h0000_0003);
      chk_bit(irq, 1'b0);
      phyStat.link100Fdx <= 1'b1;
      repeat (4) @(posedge clk);
      chk_bit(irq, 1'b1);
      ahb_read(A_PHY);
      chk_bit(rd[11], 1'b1);
      ahb_read(A_STAT);
      chk_reg(rd, 32'h0000_0001);
      ahb_write(A_MASK, 32'h0);
      chk_bit(irq, 1'b0);
      ahb_write(A_MASK, 32'h0000_0001);
      chk_bit(irq, 1'b1);
      ahb_write(A_STAT, 32'h0000_0001);
      chk_bit(irq, 1'b0);
      $display("test interrupt done");

      ahb_write(A_LED, 32'h0000_0080);
      ahb_write(A_PHY, 32'h0000_00A0);
      phyStat.linkUp <= 1'b1;
      repeat (3) @(posedge clk);
      chk_bit(statusLedPinOut, 1'b1);
      ahb_write(A_LED, 32'h0000_0000);
      chk_bit(statusLedPinOut, 1'b0);
      phyStat.linkUp <= 1'b0;
      repeat (3) @(posedge clk);
      chk_bit(statusLedPinOut, 1'b1);
      phyStat.linkUp <= 1'b1;
      phyStat.activity <= 1'b1;
      for (int r = 0; r < 8; r++) begin
         ahb_write(A_LED, 32'h0000_0080 | (32'(r % 4) << 9));
         ahb_write(A_PHY, r < 4 ? 32'h0000_0080 : 32'h0);
         wait_toggle(gap);
         wait_toggle(gap);
         wait_toggle(gap);
         chk_reg(32'(gap), 32'(PH[r % 4]));
      end
      // Activity drops early in an off phase, so only the stretcher can keep the LED off.
      for (int b = 0; b < 2; b++) begin
         ahb_write(A_PHY, b == 0 ? 32'h0000_0080 : 32'h0);
         phyStat.activity <= 1'b1;
         wait_toggle(gap);
         if (statusLedPinOut === 1'b1) begin
            wait_toggle(gap);
         end
         phyStat.activity <= 1'b0;
         repeat (3) @(posedge clk);
         chk_bit(statusLedPinOut, b == 0);
      end
      $display("test blink done");
      stop_test();
   end
endmodule
